//--- core/ipn_consts.vh
// Constants for the phase correction and oscillator offset register slice
`ifndef IPN_CONSTS_VH
`define IPN_CONSTS_VH

// Register indices; byte address is four times the index
`define IPN_IDX_CD_QMC_LOW      6'h0e
`define IPN_IDX_CD_QMC_HIGH     6'h0f
`define IPN_IDX_CD_IQ_PHASE     6'h11
`define IPN_IDX_AB_NCO_OFFSET   6'h12
`define IPN_IDX_CD_NCO_OFFSET   6'h13
`define IPN_IDX_AB_FREQ_LOW     6'h14
`define IPN_IDX_AB_FREQ_HIGH    6'h15
`define IPN_IDX_CD_FREQ_LOW     6'h16
`define IPN_IDX_CD_FREQ_HIGH    6'h17
`define IPN_IDX_QMC_SYNC_EN     6'h1e
`define IPN_IDX_MIXER_SYNC_EN   6'h1f

// Reset values
`define IPN_RST_ZERO16          16'h0000
`define IPN_RST_ZERO32          32'h0000_0000
`define IPN_RST_ZERO12          12'h000
`define IPN_RST_READY           1'b1
`define IPN_RST_QMC_LOW         16'h0400
`define IPN_RST_QMC_HIGH        16'h0400
`define IPN_RST_SYNC_EN         1'b0

// Field layout
`define IPN_PHASE_MSB           11
`define IPN_SYNC_EN_BIT         0
`define IPN_PHASE_FRAC_BITS     12

// AHB transfer type bit that marks NONSEQ or SEQ
`define IPN_HTRANS_ACTIVE_BIT   1
`define IPN_HRESP_OKAY          1'b0

`endif

//--- core/ipn_nco_offset_regs.v
// Phase correction and oscillator offset registers with AHB-Lite access
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "ipn_consts.vh"

////////////////////////////////////////////////////////////////////////////
// One oscillator path: accumulator plus phase offset into a table index
module ipn_nco (
  input  wire        mclk,
  input  wire        reset,
  input  wire [31:0] freq_word,
  input  wire [15:0] offset_word,
  output reg  [15:0] lut_index
);
  reg [31:0] acc_q;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc_q     <= `IPN_RST_ZERO32;
      lut_index <= `IPN_RST_ZERO16;
    end else begin
      acc_q     <= acc_q + freq_word;
      // Offset joins only the upper half, so it never carries downward
      lut_index <= acc_q[31:16] + offset_word;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// One software-written staging register with its own write strobe
module ipn_stage_reg #(
  parameter             WIDTH   = 16,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             mclk,
  input  wire             reset,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  output reg  [WIDTH-1:0] value_q
);
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      value_q <= RST_VAL;
    end else if (wr_en) begin
      value_q <= wr_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Register slice top
module ipn_nco_offset_regs (
  input  wire        mclk,
  input  wire        reset,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [15:0] c_sample,
  input  wire [15:0] d_sample,
  output reg  [15:0] c_corrected,
  output reg  [15:0] cd_qmc_active_low,
  output reg  [15:0] cd_qmc_active_high,
  output reg  [11:0] cd_iq_phase_word,
  output reg  [15:0] ab_nco_offset_word,
  output reg  [15:0] cd_nco_offset_word,
  output reg  [31:0] ab_freq_word,
  output reg  [31:0] cd_freq_word,
  output wire [15:0] ab_lut_index,
  output wire [15:0] cd_lut_index
);

  //////////////////////////////////////////////////////////////////////////
  // Staged copies written by software
  wire [15:0] cd_qmc_staging_low_q;
  wire [15:0] cd_qmc_staging_high_q;
  wire [11:0] cd_iq_phase_correction_q;
  wire [15:0] ab_nco_phase_offset_q;
  wire [15:0] cd_nco_phase_offset_q;
  wire [15:0] ab_freq_word_low_q;
  wire [15:0] ab_freq_word_high_q;
  wire [15:0] cd_freq_word_low_q;
  wire [15:0] cd_freq_word_high_q;
  wire        qmc_sync_enable_q;
  wire        mixer_sync_enable_q;

  //////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  reg        wr_pend_q;
  reg [5:0]  wr_idx_q;
  wire       addr_ok;
  wire       xfer;
  wire [5:0] a_idx;

  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
  assign xfer    = hsel & htrans[`IPN_HTRANS_ACTIVE_BIT] & hready;
  assign a_idx   = haddr[7:2];

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 6'h00;
    end else if (hready) begin
      // Unmapped addresses never become a write; they answer OKAY
      wr_pend_q <= xfer & hwrite & addr_ok;
      wr_idx_q  <= a_idx;
    end
  end

  // Write strobes, one per register, in the data phase
  wire we_qmc_lo  = wr_pend_q && (wr_idx_q == `IPN_IDX_CD_QMC_LOW);
  wire we_qmc_hi  = wr_pend_q && (wr_idx_q == `IPN_IDX_CD_QMC_HIGH);
  wire we_iq_ph   = wr_pend_q && (wr_idx_q == `IPN_IDX_CD_IQ_PHASE);
  wire we_ab_off  = wr_pend_q && (wr_idx_q == `IPN_IDX_AB_NCO_OFFSET);
  wire we_cd_off  = wr_pend_q && (wr_idx_q == `IPN_IDX_CD_NCO_OFFSET);
  wire we_ab_flo  = wr_pend_q && (wr_idx_q == `IPN_IDX_AB_FREQ_LOW);
  wire we_ab_fhi  = wr_pend_q && (wr_idx_q == `IPN_IDX_AB_FREQ_HIGH);
  wire we_cd_flo  = wr_pend_q && (wr_idx_q == `IPN_IDX_CD_FREQ_LOW);
  wire we_cd_fhi  = wr_pend_q && (wr_idx_q == `IPN_IDX_CD_FREQ_HIGH);
  wire we_qmc_en  = wr_pend_q && (wr_idx_q == `IPN_IDX_QMC_SYNC_EN);
  wire we_mix_en  = wr_pend_q && (wr_idx_q == `IPN_IDX_MIXER_SYNC_EN);

  //////////////////////////////////////////////////////////////////////////
  // Staging register writes
  ipn_stage_reg #(.WIDTH(16), .RST_VAL(`IPN_RST_QMC_LOW)) u_qmc_lo (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_qmc_lo),
    .wr_data (hwdata[15:0]),
    .value_q (cd_qmc_staging_low_q)
  );

  ipn_stage_reg #(.WIDTH(16), .RST_VAL(`IPN_RST_QMC_HIGH)) u_qmc_hi (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_qmc_hi),
    .wr_data (hwdata[15:0]),
    .value_q (cd_qmc_staging_high_q)
  );

  // Factory bits are not kept, so they always read zero
  ipn_stage_reg #(.WIDTH(12), .RST_VAL(`IPN_RST_ZERO12)) u_iq_ph (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_iq_ph),
    .wr_data (hwdata[`IPN_PHASE_MSB:0]),
    .value_q (cd_iq_phase_correction_q)
  );

  ipn_stage_reg #(.WIDTH(16), .RST_VAL(`IPN_RST_ZERO16)) u_ab_off (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_ab_off),
    .wr_data (hwdata[15:0]),
    .value_q (ab_nco_phase_offset_q)
  );

  ipn_stage_reg #(.WIDTH(16), .RST_VAL(`IPN_RST_ZERO16)) u_cd_off (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_cd_off),
    .wr_data (hwdata[15:0]),
    .value_q (cd_nco_phase_offset_q)
  );

  ipn_stage_reg #(.WIDTH(16), .RST_VAL(`IPN_RST_ZERO16)) u_ab_flo (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_ab_flo),
    .wr_data (hwdata[15:0]),
    .value_q (ab_freq_word_low_q)
  );

  ipn_stage_reg #(.WIDTH(16), .RST_VAL(`IPN_RST_ZERO16)) u_ab_fhi (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_ab_fhi),
    .wr_data (hwdata[15:0]),
    .value_q (ab_freq_word_high_q)
  );

  ipn_stage_reg #(.WIDTH(16), .RST_VAL(`IPN_RST_ZERO16)) u_cd_flo (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_cd_flo),
    .wr_data (hwdata[15:0]),
    .value_q (cd_freq_word_low_q)
  );

  ipn_stage_reg #(.WIDTH(16), .RST_VAL(`IPN_RST_ZERO16)) u_cd_fhi (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_cd_fhi),
    .wr_data (hwdata[15:0]),
    .value_q (cd_freq_word_high_q)
  );

  ipn_stage_reg #(.WIDTH(1), .RST_VAL(`IPN_RST_SYNC_EN)) u_qmc_en (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_qmc_en),
    .wr_data (hwdata[`IPN_SYNC_EN_BIT]),
    .value_q (qmc_sync_enable_q)
  );

  ipn_stage_reg #(.WIDTH(1), .RST_VAL(`IPN_RST_SYNC_EN)) u_mix_en (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (we_mix_en),
    .wr_data (hwdata[`IPN_SYNC_EN_BIT]),
    .value_q (mixer_sync_enable_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // Auto-sync: last-written register of a group pushes the whole group
  wire qmc_sync = we_iq_ph  & qmc_sync_enable_q;
  wire ab_sync  = we_ab_off & mixer_sync_enable_q;
  wire cd_sync  = we_cd_off & mixer_sync_enable_q;

  // Active copies take fresh bus data for the triggering register
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cd_qmc_active_low  <= `IPN_RST_QMC_LOW;
      cd_qmc_active_high <= `IPN_RST_QMC_HIGH;
      cd_iq_phase_word   <= `IPN_RST_ZERO12;
    end else if (qmc_sync) begin
      // Staging writes alone never reach here
      cd_qmc_active_low  <= cd_qmc_staging_low_q;
      cd_qmc_active_high <= cd_qmc_staging_high_q;
      cd_iq_phase_word   <= hwdata[`IPN_PHASE_MSB:0];
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ab_nco_offset_word <= `IPN_RST_ZERO16;
      ab_freq_word       <= `IPN_RST_ZERO32;
    end else if (ab_sync) begin
      ab_nco_offset_word <= hwdata[15:0];
      // High half is the upper 16 bits of the 32-bit step
      ab_freq_word <= {ab_freq_word_high_q, ab_freq_word_low_q};
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cd_nco_offset_word <= `IPN_RST_ZERO16;
      cd_freq_word       <= `IPN_RST_ZERO32;
    end else if (cd_sync) begin
      cd_nco_offset_word <= hwdata[15:0];
      cd_freq_word <= {cd_freq_word_high_q, cd_freq_word_low_q};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path: data registered at the address phase edge
  reg [15:0] rd_val;

  always @* begin
    case (a_idx)
      `IPN_IDX_CD_QMC_LOW:    rd_val = cd_qmc_staging_low_q;
      `IPN_IDX_CD_QMC_HIGH:   rd_val = cd_qmc_staging_high_q;
      `IPN_IDX_CD_IQ_PHASE:   rd_val = {4'h0, cd_iq_phase_correction_q};
      `IPN_IDX_AB_NCO_OFFSET: rd_val = ab_nco_phase_offset_q;
      `IPN_IDX_CD_NCO_OFFSET: rd_val = cd_nco_phase_offset_q;
      `IPN_IDX_AB_FREQ_LOW:   rd_val = ab_freq_word_low_q;
      `IPN_IDX_AB_FREQ_HIGH:  rd_val = ab_freq_word_high_q;
      `IPN_IDX_CD_FREQ_LOW:   rd_val = cd_freq_word_low_q;
      `IPN_IDX_CD_FREQ_HIGH:  rd_val = cd_freq_word_high_q;
      `IPN_IDX_QMC_SYNC_EN:   rd_val = {15'h0000, qmc_sync_enable_q};
      `IPN_IDX_MIXER_SYNC_EN: rd_val = {15'h0000, mixer_sync_enable_q};
      default:                rd_val = 16'h0000;
    endcase
  end

  // A write landing on this same edge would be missed; forward it
  reg [15:0] rd_fwd;

  always @* begin
    rd_fwd = rd_val;
    if (wr_pend_q && (wr_idx_q == a_idx)) begin
      if (a_idx == `IPN_IDX_CD_IQ_PHASE) begin
        rd_fwd = {4'h0, hwdata[`IPN_PHASE_MSB:0]};
      end else if ((a_idx == `IPN_IDX_QMC_SYNC_EN) ||
                   (a_idx == `IPN_IDX_MIXER_SYNC_EN)) begin
        rd_fwd = {15'h0000, hwdata[`IPN_SYNC_EN_BIT]};
      end else begin
        rd_fwd = hwdata[15:0];
      end
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      hrdata    <= `IPN_RST_ZERO32;
      hreadyout <= `IPN_RST_READY;
      hresp     <= `IPN_HRESP_OKAY;
    end else begin
      // Zero-wait slave; every transfer answers OKAY
      hreadyout <= 1'b1;
      hresp     <= `IPN_HRESP_OKAY;
      if (xfer && !hwrite) begin
        hrdata <= addr_ok ? {16'h0000, rd_fwd} : `IPN_RST_ZERO32;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // CD phase correction: C plus D times phase, phase scaled by 2^-12
  wire signed [15:0] d_s   = d_sample;
  wire signed [15:0] c_s   = c_sample;
  wire signed [11:0] ph_s  = cd_iq_phase_word;
  wire signed [27:0] prod  = d_s * ph_s;
  wire signed [15:0] prod_sc = prod[27:`IPN_PHASE_FRAC_BITS];
  wire signed [16:0] sum   = {c_s[15], c_s} + {prod_sc[15], prod_sc};

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      c_corrected <= `IPN_RST_ZERO16;
    end else begin
      // Saturate rather than wrap so a large tweak cannot flip sign
      if (sum[16] != sum[15]) begin
        c_corrected <= sum[16] ? 16'h8000 : 16'h7fff;
      end else begin
        c_corrected <= sum[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Two oscillator paths fed from the active copies only
  ipn_nco u_ab_nco (
    .mclk        (mclk),
    .reset       (reset),
    .freq_word   (ab_freq_word),
    .offset_word (ab_nco_offset_word),
    .lut_index   (ab_lut_index)
  );

  ipn_nco u_cd_nco (
    .mclk        (mclk),
    .reset       (reset),
    .freq_word   (cd_freq_word),
    .offset_word (cd_nco_offset_word),
    .lut_index   (cd_lut_index)
  );

endmodule

//--- bench/ipn_nco_offset_regs_asserts.sv
// Checker for the phase correction and oscillator offset register slice
`timescale 1ns/1ns
`include "ipn_consts.vh"
module ipn_regs_chk (
  input wire        mclk,
  input wire        reset,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [15:0] cd_qmc_active_low,
  input wire [15:0] cd_qmc_active_high,
  input wire [11:0] cd_iq_phase_word,
  input wire [15:0] ab_nco_offset_word,
  input wire [15:0] cd_nco_offset_word,
  input wire [31:0] ab_freq_word,
  input wire [31:0] cd_freq_word,
  input wire [15:0] ab_lut_index
);
  reg       wr_q;
  reg       rd_q;
  reg [5:0] idx_q;
  reg       qen_q;
  reg       men_q;
  wire      take = hsel & htrans[1] & hready;
  wire      w_ph = wr_q && idx_q == `IPN_IDX_CD_IQ_PHASE;
  wire      w_ab = wr_q && idx_q == `IPN_IDX_AB_NCO_OFFSET;
  wire      w_cd = wr_q && idx_q == `IPN_IDX_CD_NCO_OFFSET;

  ////////////////////////////////////////////////////////////////////////////
  // Mirror of the data phase and the two sync enables
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 6'h00;
      qen_q <= 1'b0;
      men_q <= 1'b0;
    end else begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      idx_q <= haddr[7:2];
      if (wr_q && idx_q == `IPN_IDX_QMC_SYNC_EN) qen_q <= hwdata[0];
      if (wr_q && idx_q == `IPN_IDX_MIXER_SYNC_EN) men_q <= hwdata[0];
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  phase_cause_a: assert property (
    !$stable(cd_iq_phase_word) |-> $past(w_ph && qen_q))
    else $error("active phase word changed without sync");
  qmc_hold_a: assert property (
    !$stable({cd_qmc_active_low, cd_qmc_active_high}) |-> $past(w_ph && qen_q))
    else $error("active qmc words changed without sync");
  ab_hold_a: assert property (
    !$stable({ab_freq_word, ab_nco_offset_word}) |-> $past(w_ab && men_q))
    else $error("active ab mixer changed without sync");
  cd_hold_a: assert property (
    !$stable({cd_freq_word, cd_nco_offset_word}) |-> $past(w_cd && men_q))
    else $error("active cd mixer changed without sync");
  phase_load_a: assert property (
    w_ph && qen_q |=> cd_iq_phase_word == $past(hwdata[11:0]))
    else $error("phase word not loaded on sync");
  ab_load_a: assert property (
    w_ab && men_q |=> ab_nco_offset_word == $past(hwdata[15:0]))
    else $error("ab offset not loaded on sync");
  cd_load_a: assert property (
    w_cd && men_q |=> cd_nco_offset_word == $past(hwdata[15:0]))
    else $error("cd offset not loaded on sync");
  rsv_read_a: assert property (
    rd_q && idx_q == `IPN_IDX_CD_IQ_PHASE |-> hrdata[31:12] == 20'h00000)
    else $error("reserved phase bits read nonzero");
  // Low half zero keeps carries out of the table index
  lut_step_a: assert property (
    $stable(ab_freq_word) && $stable(ab_nco_offset_word) &&
    ab_freq_word[15:0] == 16'h0000
    |=> ab_lut_index == $past(ab_lut_index) + $past(ab_freq_word[31:16]))
    else $error("ab table index step wrong");

  cover property (w_ph && qen_q);
  cover property (w_ab && men_q);
  cover property (w_cd && men_q);
endmodule

bind ipn_nco_offset_regs ipn_regs_chk u_chk (
  .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .cd_qmc_active_low(cd_qmc_active_low),
  .cd_qmc_active_high(cd_qmc_active_high),
  .cd_iq_phase_word(cd_iq_phase_word),
  .ab_nco_offset_word(ab_nco_offset_word),
  .cd_nco_offset_word(cd_nco_offset_word), .ab_freq_word(ab_freq_word),
  .cd_freq_word(cd_freq_word), .ab_lut_index(ab_lut_index));

//--- bench/ipn_nco_offset_regs_bench.sv
// Self-checking bench for the phase correction and offset registers
`timescale 1ns/1ns
`include "ipn_consts.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module ipn_nco_offset_regs_bench;
  reg         mclk;
  reg         reset;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg  [15:0] c_s;
  reg  [15:0] d_s;
  reg  [31:0] rd_v;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire [15:0] c_cor;
  wire [15:0] qlo;
  wire [15:0] qhi;
  wire [11:0] ph;
  wire [15:0] ab_off;
  wire [15:0] cd_off;
  wire [31:0] ab_fw;
  wire [31:0] cd_fw;
  wire [15:0] ab_lut;
  wire [15:0] cd_lut;
  integer     num_errors;
  integer     num_checks;
  integer     p;

  // Bus hready is the single slave's hreadyout
  ipn_nco_offset_regs u_dut (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .c_sample(c_s), .d_sample(d_s), .c_corrected(c_cor),
    .cd_qmc_active_low(qlo), .cd_qmc_active_high(qhi),
    .cd_iq_phase_word(ph), .ab_nco_offset_word(ab_off),
    .cd_nco_offset_word(cd_off), .ab_freq_word(ab_fw),
    .cd_freq_word(cd_fw), .ab_lut_index(ab_lut), .cd_lut_index(cd_lut));

  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task xfer(input w, input [31:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= {16'h0000, d};
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd_v = hrdata;
      // Let the storing edge land before anyone looks
      #1;
    end
  endtask
  task wr(input [5:0] i, input [15:0] d);
    xfer(1'b1, {24'h000000, i, 2'b00}, d);
  endtask
  task rd(input [5:0] i);
    xfer(1'b0, {24'h000000, i, 2'b00}, 16'h0000);
  endtask
  task smp(input [15:0] c, input [15:0] d);
    begin
      @(posedge mclk);
      c_s <= c;
      d_s <= d;
      repeat (2) @(posedge mclk);
      #1;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    num_errors++;
    $display("watchdog expired");
    end_of_test;
  end

  initial begin
    {mclk, hsel, hwrite, htrans, haddr, hwdata, c_s, d_s} = 0;
    reset = 1'b1;
    num_errors = 0;
    num_checks = 0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    for (p = 0; p < 3; p++) begin
      rd(`IPN_IDX_CD_IQ_PHASE + p[5:0]);
      `CHK("slice reset", 32'h00000000, rd_v)
    end
    $display("reset test done");
    wr(`IPN_IDX_CD_IQ_PHASE, 16'hffff);
    rd(`IPN_IDX_CD_IQ_PHASE);
    `CHK("reserved bits", 32'h00000fff, rd_v)
    `CHK("phase unsynced", 12'h000, ph)
    xfer(1'b1, 32'h00000100, 16'h5a5a);
    xfer(1'b0, 32'h00000100, 16'h0000);
    `CHK("unmapped read", 32'h00000000, rd_v)
    $display("reserved test done");
    wr(`IPN_IDX_QMC_SYNC_EN, 16'h0001);
    wr(`IPN_IDX_CD_QMC_LOW, 16'h0123);
    wr(`IPN_IDX_CD_QMC_HIGH, 16'h0234);
    `CHK("qmc staged", 32'h04000400, {qhi, qlo})
    wr(`IPN_IDX_CD_IQ_PHASE, 16'h0400);
    `CHK("phase synced", 12'h400, ph)
    `CHK("qmc synced", 32'h02340123, {qhi, qlo})
    smp(16'h0100, 16'h1000);
    `CHK("c plus quarter d", 16'h0500, c_cor)
    wr(`IPN_IDX_CD_IQ_PHASE, 16'h0800);
    smp(16'h0000, 16'h1000);
    `CHK("most negative phase", 16'hf800, c_cor)
    smp(16'h8000, 16'h7fff);
    `CHK("saturate low", 16'h8000, c_cor)
    $display("qmc test done");
    wr(`IPN_IDX_MIXER_SYNC_EN, 16'h0001);
    for (p = 0; p < 2; p++) begin
      wr(`IPN_IDX_AB_NCO_OFFSET + p[5:0], 16'h1234 + p[15:0]);
      @(posedge mclk);
      #1;
      `CHK("offset index", 16'h1234 + p[15:0], p ? cd_lut : ab_lut)
      wr(`IPN_IDX_AB_FREQ_LOW + 2 * p[5:0], p ? 16'h5678 : 16'h0000);
      wr(`IPN_IDX_AB_FREQ_HIGH + 2 * p[5:0], 16'h0003);
      `CHK("freq staged", 32'h00000000, p ? cd_fw : ab_fw)
      wr(`IPN_IDX_AB_NCO_OFFSET + p[5:0], 16'h0010);
      `CHK("freq synced", p ? 32'h00035678 : 32'h00030000,
           p ? cd_fw : ab_fw)
      `CHK("offset synced", 16'h0010, p ? cd_off : ab_off)
    end
    repeat (8) @(posedge mclk);
    $display("mixer test done");
    end_of_test;
  end
endmodule
